// ===== verilog/adcc_top.sv
// conversion clock select, sar sequencer and analog pin configuration
//============================================================
`timescale 1ns/10ps
`default_nettype none
`include "adcc_cfg.svh"
module adcc_top (
    // clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      reset_i,
    // register port
    input  wire logic [`ADCC_ADDR_W-1:0]   reg_addr_i,
    input  wire logic [`ADCC_DATA_W-1:0]   reg_wdata_i,
    input  wire logic                      reg_write_i,
    input  wire logic                      reg_read_i,
    output logic      [`ADCC_DATA_W-1:0]   reg_rdata_o,
    // port pins
    input  wire logic [`ADCC_PINS-1:0]     pin_level_i,
    output logic      [`ADCC_PINS-1:0]     pin_out_o,
    output logic      [`ADCC_PINS-1:0]     pin_oe_n_o,
    // analog front end
    input  wire logic                      adc_compare_i,
    output logic                           adc_sample_o,
    output logic      [3:0]                adc_channel_o,
    output logic                           adc_src_digital_o,
    output logic                           adc_drive_level_o,
    output logic      [`ADCC_RES_BITS-1:0] adc_trial_o,
    output logic                           adc_tad_tick_o,
    output logic                           conv_busy_o,
    output logic                           conv_done_o
);
    import adcc_pkg::*;

    // terminal count of the period counter for a select value
    function automatic logic [8:0] tad_term(input adcc_sel_type sel);
        logic [8:0] div;
        div = 9'h002 << {sel[1:0], 1'b0};
        if (sel[1:0] == 2'h3) begin
            tad_term = 9'((`ADCC_RC_TAD_CYC) - 1);
        end else if (sel[2]) begin
            tad_term = 9'((div << 1) - 9'h001);
        end else begin
            tad_term = div - 9'h001;
        end
    endfunction

    //============================================================
    // registers
    adcc_sel_type                conv_clock_select;  // bit period source
    logic [3:0]                  channel_select;     // converted channel
    logic [`ADCC_PINS-1:0]       pin_direction_bits; // 1 input, 0 output
    logic [`ADCC_PINS-1:0]       analog_port_config; // 1 analog input
    logic [`ADCC_PINS-1:0]       port_latch;         // driven pin levels
    logic [`ADCC_RES_BITS-1:0]   result;             // last conversion
    logic [`ADCC_RES_BITS-1:0]   sar;                // trial code
    logic [`ADCC_RES_BITS-1:0]   sar_mask;           // bit under test
    logic [8:0]                  per_cnt;            // oscillator periods
    logic [3:0]                  tad_cnt;            // bit periods done
    logic                        done;               // sticky finish flag
    adcc_state_type              state;              // sequencer state

    //============================================================
    // decode
    wire ctrl_wr  = reg_write_i && (reg_addr_i == `ADCC_REG_CTRL);
    wire start    = ctrl_wr && reg_wdata_i[`ADCC_GO_BIT] && (state == ADCC_IDLE);
    wire [2:0] wsel = reg_wdata_i[`ADCC_SEL_HI:`ADCC_SEL_LO];
    // a new select restarts the count at the edge that writes it, so the
    // first period under the new select is never one cycle too long
    wire sel_chg  = ctrl_wr && (wsel != conv_clock_select);
    wire restart  = sel_chg || start;
    wire tick     = (per_cnt == tad_term(conv_clock_select));
    wire conv_tick = tick && (state == ADCC_CONV) && !restart;
    wire last_tad = conv_tick && (tad_cnt == `ADCC_TAD_LAST);
    wire sar_tad  = conv_tick && (tad_cnt < 4'(`ADCC_RES_BITS));
    wire [15:0] dir_ext = {4'hf, pin_direction_bits};
    wire [15:0] lat_ext = {4'h0, port_latch};
    wire [`ADCC_PINS-1:0] pin_read = pin_level_i & ~analog_port_config;
    wire [`ADCC_DATA_W-1:0] rd_mux =
        (reg_addr_i == `ADCC_REG_CTRL) ? 16'({done, state, channel_select, conv_clock_select}) :
        (reg_addr_i == `ADCC_REG_DIR)  ? 16'(pin_direction_bits) :
        (reg_addr_i == `ADCC_REG_ACFG) ? 16'(analog_port_config) :
        (reg_addr_i == `ADCC_REG_POUT) ? 16'(port_latch) :
        (reg_addr_i == `ADCC_REG_PIN)  ? 16'(pin_read) :
        (reg_addr_i == `ADCC_REG_RES)  ? 16'(result) :
        (reg_addr_i == `ADCC_REG_STAT) ? 16'({tad_cnt, done, state}) :
        16'h0000;

    //============================================================
    // software registers
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            conv_clock_select  <= `ADCC_SEL_RST;
            channel_select     <= 4'h0;
            pin_direction_bits <= `ADCC_DIR_RST;
            analog_port_config <= `ADCC_ACFG_RST;
            port_latch         <= 12'h000;
        end else if (reg_write_i) begin
            // address chain
            if (reg_addr_i == `ADCC_REG_CTRL) begin
                conv_clock_select <= wsel;
                channel_select    <= reg_wdata_i[`ADCC_CH_HI:`ADCC_CH_LO];
            end else if (reg_addr_i == `ADCC_REG_DIR) begin
                pin_direction_bits <= reg_wdata_i[`ADCC_PINS-1:0];
            end else if (reg_addr_i == `ADCC_REG_ACFG) begin
                analog_port_config <= reg_wdata_i[`ADCC_PINS-1:0];
            end else if (reg_addr_i == `ADCC_REG_POUT) begin
                port_latch <= reg_wdata_i[`ADCC_PINS-1:0];
            end
        end
    end

    //============================================================
    // free-running oscillator period counter
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            per_cnt  <= 9'h000;
        end else begin
            // restart and the terminal count both bring the count back to zero
            per_cnt  <= (restart || tick) ? 9'h000 : per_cnt + 9'h001;
        end
    end

    //============================================================
    // sequencer: never looks at channel or direction
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state    <= ADCC_IDLE;
            tad_cnt  <= 4'h0;
            sar      <= 10'h000;
            sar_mask <= 10'h000;
            result   <= 10'h000;
            done     <= 1'b0;
        end else begin
            if (start) begin
                state    <= ADCC_CONV;
                tad_cnt  <= 4'h0;
                sar      <= `ADCC_SAR_MSB;
                sar_mask <= `ADCC_SAR_MSB;
            end else if (last_tad) begin
                state  <= ADCC_IDLE;
                result <= sar;
            end else if (conv_tick) begin
                tad_cnt <= tad_cnt + 4'h1;
            end
            // sar step once per bit period in the first ten of the twelve bit periods
            if (sar_tad) begin
                sar      <= (adc_compare_i ? sar : (sar & ~sar_mask)) | (sar_mask >> 1);
                sar_mask <= sar_mask >> 1;
            end
            // finish sets, a new start clears; set wins
            if (last_tad) begin
                done <= 1'b1;
            end else if (start) begin
                done <= 1'b0;
            end
        end
    end

    //============================================================
    // registered outputs
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_o       <= 16'h0000;
            pin_out_o         <= 12'h000;
            pin_oe_n_o        <= `ADCC_DIR_RST;
            adc_sample_o      <= 1'b0;
            adc_channel_o     <= 4'h0;
            adc_src_digital_o <= 1'b0;
            adc_drive_level_o <= 1'b0;
            adc_trial_o       <= 10'h000;
            adc_tad_tick_o    <= 1'b0;
            conv_busy_o       <= 1'b0;
            conv_done_o       <= 1'b0;
        end else begin
            reg_rdata_o       <= reg_read_i ? rd_mux : 16'h0000;
            pin_out_o         <= port_latch;
            pin_oe_n_o        <= pin_direction_bits;
            adc_sample_o      <= start;
            adc_channel_o     <= channel_select;
            adc_src_digital_o <= ~dir_ext[channel_select];
            adc_drive_level_o <= lat_ext[channel_select];
            adc_trial_o       <= sar;
            adc_tad_tick_o    <= tick;
            conv_busy_o       <= (state == ADCC_CONV);
            conv_done_o       <= done;
        end
    end

    //============================================================
    // checks
    logic [15:0] conv_len;   // cycles since start
    logic        conv_clean; // select unchanged during conversion
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            conv_len   <= 16'h0000;
            conv_clean <= 1'b0;
        end else if (start) begin
            conv_len   <= 16'h0001;
            conv_clean <= 1'b1;
        end else begin
            conv_len   <= conv_len + 16'h0001;
            conv_clean <= conv_clean && !restart;
        end
    end
    wire [15:0] exp_len = 16'(`ADCC_TAD_PER) * 16'(tad_term(conv_clock_select) + 9'h001);

    sequence conv_start_s;
        start;
    endsequence
    sequence conv_first_s;
        (state == ADCC_CONV) && (tad_cnt == 4'h0);
    endsequence
    // a tick under select 100 with no restart beside it
    sequence tick_four_s;
        conv_clock_select == 3'h4 && !restart && tick;
    endsequence

    conv_length_a: assert property (@(posedge clk_i) disable iff (reset_i)
        last_tad && conv_clean |-> conv_len == exp_len)
        else $error("conversion length is not twelve bit periods");
    // a tick under select 000 is followed by one quiet cycle, then the next
    div_two_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (conv_clock_select == 3'h0 && !restart && tick) ##1 !restart |-> !tick ##1 tick)
        else $error("select 000 does not tick every two cycles");
    // select 100 spaces its ticks four oscillator periods apart
    div_four_a: assert property (@(posedge clk_i) disable iff (reset_i)
        tick_four_s ##1 !restart [*3] |-> !tick ##1 tick)
        else $error("select 100 does not tick every four cycles");
    div_table_a: assert property (@(posedge clk_i) disable iff (reset_i)
        conv_clock_select == 3'h6 |-> tad_term(conv_clock_select) == 9'h03f)
        else $error("select 110 is not sixty-four periods");
    rc_period_a: assert property (@(posedge clk_i) disable iff (reset_i)
        conv_clock_select[1:0] == 2'h3 && tick |-> per_cnt == 9'd499)
        else $error("rc bit period is not four microseconds");
    restart_cnt_a: assert property (@(posedge clk_i) disable iff (reset_i)
        conv_start_s |=> per_cnt == 9'h000 ##0 conv_first_s)
        else $error("period counter did not restart at start");
    src_dig_a: assert property (@(posedge clk_i) disable iff (reset_i)
        $stable(channel_select) && channel_select < 4'hc
        |=> adc_src_digital_o == !$past(pin_direction_bits[channel_select]))
        else $error("output pin not converted from driven level");
    port_read_a: assert property (@(posedge clk_i) disable iff (reset_i)
        reg_read_i && reg_addr_i == `ADCC_REG_PIN
        |=> (reg_rdata_o[`ADCC_PINS-1:0] & $past(analog_port_config)) == 12'h000)
        else $error("analog pin read back as nonzero");
    seq_indep_a: assert property (@(posedge clk_i) disable iff (reset_i)
        conv_start_s |=> state == ADCC_CONV && sar == `ADCC_SAR_MSB)
        else $error("conversion start was blocked");
    done_set_a: assert property (@(posedge clk_i) disable iff (reset_i)
        last_tad |=> done && state == ADCC_IDLE ##1 conv_done_o)
        else $error("finish flag not raised");

    //============================================================
    // further checks on finish, bit order and pins
    // a start clears the finish flag until the next finish
    done_clear_a: assert property (@(posedge clk_i) disable iff (reset_i)
        conv_start_s |=> !done)
        else $error("finish flag not cleared by start");
    // the bit period count never passes the twelfth period
    tad_bound_a: assert property (@(posedge clk_i) disable iff (reset_i)
        state == ADCC_CONV |-> tad_cnt <= `ADCC_TAD_LAST)
        else $error("bit period count ran past twelve");
    // bits are decided msb first, one per bit period over the first ten bit periods
    mask_order_a: assert property (@(posedge clk_i) disable iff (reset_i)
        sar_tad |-> sar_mask == (`ADCC_SAR_MSB >> tad_cnt))
        else $error("trial bit out of order");
    // the result only moves at a finish
    result_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
        !last_tad |=> $stable(result))
        else $error("result moved outside a finish");
    // busy shows one cycle after the sequencer leaves idle
    busy_level_a: assert property (@(posedge clk_i) disable iff (reset_i)
        conv_start_s |=> ##1 conv_busy_o)
        else $error("busy not raised after start");
    // any restart zeroes the period counter on the next edge
    count_zero_a: assert property (@(posedge clk_i) disable iff (reset_i)
        restart |=> per_cnt == 9'h000)
        else $error("period counter not zeroed by restart");
    // an output pin hands its latched level to the converter
    drive_level_a: assert property (@(posedge clk_i) disable iff (reset_i)
        $stable(channel_select) && channel_select < 4'hc
        |=> adc_drive_level_o == $past(port_latch[channel_select]))
        else $error("driven level not passed to converter");
    // pin enables follow the direction bits one cycle later
    oe_follow_a: assert property (@(posedge clk_i) disable iff (reset_i)
        $changed(pin_direction_bits) |=> pin_oe_n_o == $past(pin_direction_bits))
        else $error("pin enables do not follow direction bits");
    // the sample pulse lasts one cycle
    sample_pulse_a: assert property (@(posedge clk_i) disable iff (reset_i)
        conv_start_s |=> adc_sample_o ##1 !adc_sample_o)
        else $error("sample pulse not one cycle wide");
endmodule // adcc_top
`default_nettype wire

// ===== include/adcc_cfg.svh
// constants for the a/d conversion clock select block
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH
// register port
`define ADCC_ADDR_W     3
`define ADCC_DATA_W     16
`define ADCC_REG_CTRL   3'h0
`define ADCC_REG_DIR    3'h1
`define ADCC_REG_ACFG   3'h2
`define ADCC_REG_POUT   3'h3
`define ADCC_REG_PIN    3'h4
`define ADCC_REG_RES    3'h5
`define ADCC_REG_STAT   3'h6
// control field positions
`define ADCC_SEL_LO     0
`define ADCC_SEL_HI     2
`define ADCC_CH_LO      3
`define ADCC_CH_HI      6
`define ADCC_GO_BIT     7
// pins and reset values
`define ADCC_PINS       12
`define ADCC_DIR_RST    12'hfff
`define ADCC_ACFG_RST   12'h000
`define ADCC_SEL_RST    3'h0
// conversion shape
`define ADCC_RES_BITS   10
`define ADCC_TAD_PER    4'hc
`define ADCC_TAD_LAST   4'hb
`define ADCC_SAR_MSB    10'h200
// timing
`define ADCC_CLK_NS     8
`define ADCC_RC_TAD_NS  4000
`define ADCC_RC_TAD_CYC (`ADCC_RC_TAD_NS / `ADCC_CLK_NS)
`endif

// ===== include/adcc_pkg.sv
// types for the a/d conversion clock select block
package adcc_pkg;
    // conversion sequencer states
    typedef enum logic [0:0] {
        ADCC_IDLE = 1'b0,
        ADCC_CONV = 1'b1
    } adcc_state_type;
    // clock select field
    typedef logic [2:0] adcc_sel_type;
endpackage

// ===== sim/adcc_tb.sv
// self-checking testbench for the conversion clock select block
`timescale 1ns/10ps
`default_nettype none
`include "adcc_cfg.svh"
module tb;
    import adcc_pkg::*;
    //============================================================
    // stimulus and observed signals
    logic                      clk_i;            // 125 mhz clock
    logic                      reset_i;          // async reset, high
    logic [`ADCC_ADDR_W-1:0]   reg_addr_i;       // register address
    logic [`ADCC_DATA_W-1:0]   reg_wdata_i;      // write data
    logic                      reg_write_i;      // write strobe
    logic                      reg_read_i;       // read strobe
    logic [`ADCC_DATA_W-1:0]   reg_rdata_o;      // read data
    logic [`ADCC_PINS-1:0]     pin_level_i;      // pin levels
    logic [`ADCC_PINS-1:0]     pin_out_o;        // port latch
    logic [`ADCC_PINS-1:0]     pin_oe_n_o;       // low = driven
    logic                      adc_compare_i;    // comparator answer
    logic                      adc_sample_o;     // sample pulse
    logic [3:0]                adc_channel_o;    // selected channel
    logic                      adc_src_digital_o; // driven level taken
    logic                      adc_drive_level_o; // driven level
    logic [`ADCC_RES_BITS-1:0] adc_trial_o;      // trial code
    logic                      adc_tad_tick_o;   // bit period tick
    logic                      conv_busy_o;      // converting
    logic                      conv_done_o;      // done level
    logic [`ADCC_RES_BITS-1:0] tgt;              // modelled input level
    int                        errors;           // mismatches
    int                        samples_checked;  // comparisons
    logic [15:0]               rdv;              // last read value
    //============================================================
    // device under test
    adcc_top adcc_top_inst (
        .clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
        .reg_rdata_o(reg_rdata_o), .pin_level_i(pin_level_i), .pin_out_o(pin_out_o),
        .pin_oe_n_o(pin_oe_n_o), .adc_compare_i(adc_compare_i),
        .adc_sample_o(adc_sample_o), .adc_channel_o(adc_channel_o),
        .adc_src_digital_o(adc_src_digital_o), .adc_drive_level_o(adc_drive_level_o),
        .adc_trial_o(adc_trial_o), .adc_tad_tick_o(adc_tad_tick_o),
        .conv_busy_o(conv_busy_o), .conv_done_o(conv_done_o)
    );
    // comparator model answers at once so short periods see the new trial
    assign adc_compare_i = (tgt >= adc_trial_o);
    //============================================================
    // clock, tasks and verdict
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // one comparison, reported at once on mismatch
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    // one-cycle write
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge clk_i);
        reg_write_i <= 1'b0;
    endtask
    // one-cycle read, data taken in the following cycle
    task automatic rd(input logic [2:0] a);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge clk_i);
        reg_read_i <= 1'b0;
        #1 rdv = reg_rdata_o;
    endtask
    // start a conversion and measure tick phase, busy span and result
    task automatic conv(input logic [2:0] sel, input logic [3:0] ch, input int div);
        int n;
        int first;
        int busy;
        n = 0;
        first = 0;
        busy = 0;
        wr(`ADCC_REG_CTRL, 16'h0080 | {9'h0, ch, sel});
        // the sample pulse stands in the cycle after the taking edge
        #1 chk(16'(adc_sample_o), 16'h0001, "sample pulse");
        // the old done level still stands at n == 0; the bus stays quiet
        // through the whole conversion, as a sleeping core keeps it
        while (n < 7000 && (n == 0 || conv_done_o !== 1'b1)) begin
            @(posedge clk_i);
            #1 n++;
            if (n == 1) chk(16'(adc_sample_o), 16'h0000, "sample pulse width");
            if (adc_tad_tick_o === 1'b1 && first == 0) first = n;
            if (conv_busy_o === 1'b1) busy++;
        end
        chk(16'(conv_done_o), 16'h0001, "done level");
        chk(16'(first), 16'(div), "first tick after start");
        chk(16'(busy), 16'(12 * div), "busy span");
        rd(`ADCC_REG_RES);
        chk(rdv, {6'h0, tgt}, "conversion result");
    endtask
    // single place where the run ends
    task automatic wrap_up();
        if (errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // watchdog well beyond the expected run length
    initial begin
        #600000;
        errors++;
        wrap_up();
    end
    //============================================================
    // main sequence
    initial begin
        logic [2:0] sels [8];
        int         divs [8];
        logic [9:0] tgts [8];
        sels = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
        divs = '{2, 4, 8, 16, 32, 64, `ADCC_RC_TAD_CYC, `ADCC_RC_TAD_CYC};
        tgts = '{10'h3ff, 10'h000, 10'h2a5, 10'h15a, 10'h201, 10'h1ff, 10'h0c3, 10'h333};
        errors = 0;
        samples_checked = 0;
        reset_i = 1'b1;
        reg_addr_i = 3'h0;
        reg_wdata_i = 16'h0000;
        reg_write_i = 1'b0;
        reg_read_i = 1'b0;
        pin_level_i = 12'hfff;
        tgt = 10'h000;
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        // reset values and an unmapped place
        rd(`ADCC_REG_DIR);
        chk(rdv, 16'h0fff, "direction reset");
        rd(`ADCC_REG_ACFG);
        chk(rdv, 16'h0000, "analog config reset");
        chk(16'(pin_oe_n_o), 16'h0fff, "output enable reset");
        wr(3'h7, 16'hffff);
        rd(3'h7);
        chk(rdv, 16'h0000, "unmapped read");
        // pins 0..3 analog, pins 4..7 outputs
        wr(`ADCC_REG_ACFG, 16'h000f);
        wr(`ADCC_REG_POUT, 16'h0a5a);
        wr(`ADCC_REG_DIR, 16'h0f0f);
        rd(`ADCC_REG_PIN);
        chk(rdv, 16'h0ff0, "analog pins read low");
        chk(16'(pin_oe_n_o), 16'h0f0f, "output enables");
        chk(16'(pin_out_o), 16'h0a5a, "port latch");
        // output pins convert driven level, digital inputs the analog level
        for (int c = 4; c < 10; c++) begin
            wr(`ADCC_REG_CTRL, {9'h0, c[3:0], 3'h0});
            @(posedge clk_i);
            #1 chk(16'(adc_channel_o), 16'(c), "channel select");
            chk(16'(adc_src_digital_o), 16'(c < 8), "driven level source");
            if (c < 8) chk(adc_drive_level_o, (12'ha5a >> c) & 1, "driven level");
        end
        // every select code, channel and direction mixed in
        for (int i = 0; i < 8; i++) begin
            tgt = tgts[i];
            conv(sels[i], i[3:0] + 4'h2, divs[i]);
        end
        // the rc source keeps the bit period above the minimum at this clock
        tgt = 10'h2c9;
        conv(3'h3, 4'h0, `ADCC_RC_TAD_CYC);
        rd(`ADCC_REG_STAT);
        chk(rdv, 16'h002e, "status after finish");
        rd(`ADCC_REG_CTRL);
        chk(rdv & 16'h0100, 16'h0100, "done flag");
        wrap_up();
    end
endmodule // tb
`default_nettype wire
